// *** common/rf_bit_framing_defines.vh ***
// Purpose: Offsets, field positions, reset values and state codes of the bit framing block
// Assumes: 6-bit register address, 8-bit data
// Notes: Included by both design files
// Function
// - A write of one to the timer stop strobe halts the timer at once and the strobe reads zero.
// - A write of one to the timer start strobe starts the timer at once and the strobe reads zero.
// - The read-only received last bits field gives the valid bits of the last byte, zero is all.
// - A write of one to the send trigger starts sending only while a transceive is active.
// - Receive alignment picks the bit slot of the first received bit; later bits fill upward.
// - Transmit last bits sets how many bits of the final byte are sent, zero meaning all eight.
// - With keep after collision at zero, bits received after a collision are cleared.
// - Collision position invalid reads one for no collision or a position beyond the field.
// - Collision position counts data bits only: 01h is bit 1, 08h bit 8 and 00h bit 32.
// - In a transceive the transmitter waits in state 001 until the send trigger is written.
`ifndef RF_BIT_FRAMING_DEFINES_VH
`define RF_BIT_FRAMING_DEFINES_VH

// Register offsets
`define ADDR_MISC_CONTROL 6'h0C
`define ADDR_BIT_FRAMING 6'h0D
`define ADDR_COLLISION 6'h0E
`define ADDR_RESERVED_0F 6'h0F
`define ADDR_RESERVED_10 6'h10
`define ADDR_IRQ_STATUS 6'h20
`define ADDR_IRQ_CLEAR 6'h21
`define ADDR_IRQ_ENABLE 6'h22

// Field positions
`define BIT_TIMER_STOP 7
`define BIT_TIMER_START 6
`define BIT_SEND_TRIGGER 7
`define BIT_KEEP_AFTER_COLL 7
`define BIT_COLL_INVALID 5

// Reset values
`define RST_ALIGN 3'h0
`define RST_TX_LAST 3'h0
`define RST_RX_LAST 3'h0
`define RST_KEEP 1'h1
`define RST_COLL_POS 5'h00
`define RST_IRQ 3'h0
`define RST_MISC_RSVD 3'h2

// Interrupt bits
`define IRQ_RX_DONE 0
`define IRQ_COLLISION 1
`define IRQ_TX_START 2

// Collision counting
`define COLL_MAX_BIT 6'h20

// Modem states
`define MS_IDLE 3'h0
`define MS_WAIT_TRIGGER 3'h1
`define MS_TRANSMIT 3'h3
`define MS_WAIT_DATA 3'h5
`define MS_RECEIVE 3'h6

`endif

// *** src/modem_sequencer.v ***
// Purpose: Transmit and receive sequencing of a transceive operation
// Assumes: Command unit holds transceive_active_i for the whole operation
// Notes: State code is visible to software through the modem state output
`timescale 1ns/1ps
`default_nettype none
`include "rf_bit_framing_defines.vh"

module modem_sequencer (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Control
  input wire transceive_active_i,
  input wire send_trigger_i,
  // Link progress
  input wire tx_done_i,
  input wire rx_start_i,
  input wire rx_end_i,
  // Status
  output reg [2:0] modem_state_a_o,
  output reg tx_start_o
);

  reg [2:0] next_state;

  always @*
  begin
    next_state = modem_state_a_o;
    case (modem_state_a_o)
      `MS_IDLE:
        if (transceive_active_i)
          next_state = `MS_WAIT_TRIGGER;
      `MS_WAIT_TRIGGER:
        if (send_trigger_i)
          next_state = `MS_TRANSMIT;
      `MS_TRANSMIT:
        if (tx_done_i)
          next_state = `MS_WAIT_DATA;
      `MS_WAIT_DATA:
        if (rx_start_i)
          next_state = `MS_RECEIVE;
      `MS_RECEIVE:
        if (rx_end_i)
          next_state = `MS_WAIT_TRIGGER;
      default:
        next_state = `MS_IDLE;
    endcase
    // Dropping the command aborts anywhere, so a stale trigger cannot send
    if (!transceive_active_i)
      next_state = `MS_IDLE;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      modem_state_a_o <= `MS_IDLE;
      tx_start_o <= 1'b0;
    end
    else
    begin
      modem_state_a_o <= next_state;
      tx_start_o <= (modem_state_a_o == `MS_WAIT_TRIGGER) && (next_state == `MS_TRANSMIT);
    end
  end

endmodule
`default_nettype wire

// *** src/rf_bit_framing_collision_ctrl.v ***
// Purpose: Framing control, received bit packing and collision status registers
// Assumes: Bit stream from the demodulator is synchronous to ref_clk_i
// Notes: rx_end_i must not share a cycle with rx_bit_valid_i
`timescale 1ns/1ps
`default_nettype none
`include "rf_bit_framing_defines.vh"

module rf_bit_framing_collision_ctrl (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Command unit
  input wire transceive_active_i,
  // Transmitter
  input wire tx_done_i,
  output reg tx_start_o,
  output reg [2:0] transmit_last_bits_o,
  // Receiver bit stream
  input wire rx_start_i,
  input wire rx_bit_valid_i,
  input wire rx_bit_i,
  input wire rx_bit_coll_i,
  input wire rx_end_i,
  // Byte output towards the buffer
  output reg rx_byte_valid_o,
  output reg [7:0] rx_byte_o,
  // Timer control
  output reg timer_start_strobe_o,
  output reg timer_stop_strobe_o,
  // Status
  output reg [2:0] modem_state_a_o,
  output reg irq_o
);

  // Software visible state
  reg [2:0] receive_alignment;
  reg [2:0] transmit_last_bits;
  reg [2:0] received_last_bits;
  reg keep_after_collision;
  reg collision_position_invalid;
  reg [4:0] collision_position;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;

  // Receive packing state
  reg [2:0] bit_slot;
  reg [7:0] byte_acc;
  reg [5:0] data_bit_count;
  reg [5:0] coll_index;
  reg coll_seen;

  // Sequencer links
  reg send_trigger;
  wire [2:0] seq_state;
  wire seq_tx_start;

  wire wr_misc;
  wire wr_framing;
  wire wr_coll;
  wire wr_clear;
  wire wr_enable;
  wire rx_bit_value;
  wire [7:0] acc_with_bit;
  wire coll_event;
  wire [2:0] irq_set;

  // Sets one bit slot of a byte to a given value
  function [7:0] put_bit;
    input [7:0] value;
    input [2:0] slot;
    input bit_in;
    reg [7:0] mask;
    begin
      mask = 8'h01 << slot;
      put_bit = bit_in ? (value | mask) : (value & ~mask);
    end
  endfunction

  // Address match qualified by the write strobe
  function is_write;
    input [5:0] addr;
    input [5:0] target;
    input wr;
    begin
      is_write = wr && (addr == target);
    end
  endfunction

  assign wr_misc = is_write(reg_addr_i, `ADDR_MISC_CONTROL, reg_wr_i);
  assign wr_framing = is_write(reg_addr_i, `ADDR_BIT_FRAMING, reg_wr_i);
  assign wr_coll = is_write(reg_addr_i, `ADDR_COLLISION, reg_wr_i);
  assign wr_clear = is_write(reg_addr_i, `ADDR_IRQ_CLEAR, reg_wr_i);
  assign wr_enable = is_write(reg_addr_i, `ADDR_IRQ_ENABLE, reg_wr_i);

  // Bits after the first collision are forced low unless software keeps them
  assign rx_bit_value = (coll_seen && !keep_after_collision) ? 1'b0 : rx_bit_i;
  assign acc_with_bit = put_bit(byte_acc, bit_slot, rx_bit_value);
  assign coll_event = rx_bit_valid_i && rx_bit_coll_i && !coll_seen;

  assign irq_set[`IRQ_RX_DONE] = rx_end_i;
  assign irq_set[`IRQ_COLLISION] = coll_event;
  assign irq_set[`IRQ_TX_START] = seq_tx_start;

  modem_sequencer u_seq (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .transceive_active_i(transceive_active_i),
    .send_trigger_i(send_trigger),
    .tx_done_i(tx_done_i),
    .rx_start_i(rx_start_i),
    .rx_end_i(rx_end_i),
    .modem_state_a_o(seq_state),
    .tx_start_o(seq_tx_start)
  );

  // Configuration writes and one-cycle strobes
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      receive_alignment <= `RST_ALIGN;
      transmit_last_bits <= `RST_TX_LAST;
      keep_after_collision <= `RST_KEEP;
      irq_enable <= `RST_IRQ;
      send_trigger <= 1'b0;
      timer_start_strobe_o <= 1'b0;
      timer_stop_strobe_o <= 1'b0;
    end
    else
    begin
      // Strobe bits are never stored, so they always read back as zero
      timer_stop_strobe_o <= wr_misc && reg_wdata_i[`BIT_TIMER_STOP];
      timer_start_strobe_o <= wr_misc && reg_wdata_i[`BIT_TIMER_START];
      send_trigger <= wr_framing && reg_wdata_i[`BIT_SEND_TRIGGER] && transceive_active_i;
      if (wr_framing)
      begin
        receive_alignment <= reg_wdata_i[6:4];
        transmit_last_bits <= reg_wdata_i[2:0];
      end
      if (wr_coll)
        keep_after_collision <= reg_wdata_i[`BIT_KEEP_AFTER_COLL];
      if (wr_enable)
        irq_enable <= reg_wdata_i[2:0];
    end
  end

  // Receive bit packing into buffer bytes
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_slot <= 3'h0;
      byte_acc <= 8'h00;
      data_bit_count <= 6'h00;
      coll_index <= 6'h00;
      coll_seen <= 1'b0;
      rx_byte_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end
    else
    begin
      rx_byte_valid_o <= 1'b0;
      if (rx_start_i)
      begin
        bit_slot <= receive_alignment;
        byte_acc <= 8'h00;
        data_bit_count <= 6'h00;
        coll_index <= 6'h00;
        coll_seen <= 1'b0;
      end
      else if (rx_bit_valid_i)
      begin
        // Saturate past the field range; anything above 32 only needs to read invalid
        if (data_bit_count != 6'h3F)
          data_bit_count <= data_bit_count + 6'h01;
        if (coll_event)
        begin
          coll_seen <= 1'b1;
          coll_index <= (data_bit_count == 6'h3F) ? 6'h3F : data_bit_count + 6'h01;
        end
        bit_slot <= bit_slot + 3'h1;
        if (bit_slot == 3'h7)
        begin
          // Slot 7 closes the byte; the next bit lands at slot 0 of a new byte
          rx_byte_valid_o <= 1'b1;
          rx_byte_o <= acc_with_bit;
          byte_acc <= 8'h00;
        end
        else
          byte_acc <= acc_with_bit;
      end
      else if (rx_end_i && (bit_slot != 3'h0))
      begin
        rx_byte_valid_o <= 1'b1;
        rx_byte_o <= byte_acc;
        byte_acc <= 8'h00;
        bit_slot <= 3'h0;
      end
    end
  end

  // Frame status captured when a reception ends
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      received_last_bits <= `RST_RX_LAST;
      collision_position_invalid <= 1'b1;
      collision_position <= `RST_COLL_POS;
    end
    else if (rx_end_i)
    begin
      received_last_bits <= bit_slot;
      collision_position_invalid <= !coll_seen || (coll_index > `COLL_MAX_BIT);
      collision_position <= coll_index[4:0];
    end
  end

  // Sticky events; a set in the same cycle as a clear wins
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_status <= `RST_IRQ;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~(wr_clear ? reg_wdata_i[2:0] : 3'h0)) | irq_set;
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // Outputs registered here so every top output comes from a flip-flop of this module
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_start_o <= 1'b0;
      transmit_last_bits_o <= `RST_TX_LAST;
      modem_state_a_o <= `MS_IDLE;
    end
    else
    begin
      tx_start_o <= seq_tx_start;
      transmit_last_bits_o <= transmit_last_bits;
      modem_state_a_o <= seq_state;
    end
  end

  // Read data stands in the cycle after the read strobe only
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      case (reg_addr_i)
        `ADDR_MISC_CONTROL:
          // Reserved field keeps its reset pattern for good; writes never reach it
          reg_rdata_o <= {2'h0, `RST_MISC_RSVD, received_last_bits};
        `ADDR_BIT_FRAMING:
          reg_rdata_o <= {1'b0, receive_alignment, 1'b0, transmit_last_bits};
        `ADDR_COLLISION:
          reg_rdata_o <= {keep_after_collision, 1'b0, collision_position_invalid,
                          collision_position};
        `ADDR_IRQ_STATUS:
          reg_rdata_o <= {5'h00, irq_status};
        `ADDR_IRQ_ENABLE:
          reg_rdata_o <= {5'h00, irq_enable};
        default:
          reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** dv/framing_checker_asserts.sv ***
// Purpose: Port assertions for the bit framing block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module framing_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Link and timer side
  input wire logic transceive_active_i,
  input wire logic tx_start_o,
  input wire logic [2:0] transmit_last_bits_o,
  input wire logic rx_byte_valid_o,
  input wire logic timer_start_strobe_o,
  input wire logic timer_stop_strobe_o,
  input wire logic [2:0] modem_state_a_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic wr_misc = reg_wr_i && reg_addr_i == 6'h0C;
  wire logic trig_wr = reg_wr_i && reg_addr_i == 6'h0D && reg_wdata_i[7];
  wire logic [2:0] wd_low = reg_wdata_i[2:0];
  a_stop_pulse:
    assert property (wr_misc && reg_wdata_i[7] |=> timer_stop_strobe_o) else $error("no stop");
  a_start_pulse:
    assert property (wr_misc && reg_wdata_i[6] |=> timer_start_strobe_o) else $error("no start");
  a_misc_read:
    assert property (reg_rd_i && reg_addr_i == 6'h0C |=> reg_rdata_o[7:3] == 5'h02)
    else $error("misc upper bits");
  a_frame_read:
    assert property (reg_rd_i && reg_addr_i == 6'h0D |=> !reg_rdata_o[7] && !reg_rdata_o[3])
    else $error("framing bits");
  a_reserved_read:
    assert property (reg_rd_i && reg_addr_i inside {6'h0F, 6'h10} |=> reg_rdata_o == 8'h00)
    else $error("reserved data");
  a_trigger_gate:
    assert property ((!transceive_active_i) [*4] |-> !tx_start_o) else $error("tx without cmd");
  a_trigger_wait:
    assert property (modem_state_a_o == 3'h1 ##1 modem_state_a_o == 3'h3 |-> $past(trig_wr, 3))
    else $error("left wait state");
  a_tx_last_copy:
    assert property (reg_wr_i && reg_addr_i == 6'h0D |=> ##1
                     transmit_last_bits_o == $past(wd_low, 2))
    else $error("tx last bits");
  a_byte_pulse:
    assert property (rx_byte_valid_o |=> !rx_byte_valid_o) else $error("byte pulse long");
endmodule
`default_nettype wire

// *** dv/card_model.sv ***
// Purpose: Card side bit stream source
// Assumes: Bits arrive with one idle cycle between them
// Notes: Data line shows the inverse of the last bit when idle, so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module card_model (
  // Control
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic [31:0] data_i,
  input wire logic [31:0] coll_i,
  input wire logic [5:0] nbits_i,
  // Bit stream
  output logic rx_start_o,
  output logic rx_bit_valid_o,
  output logic rx_bit_o,
  output logic rx_bit_coll_o,
  output logic rx_end_o
);
  int i;
  initial
  begin
    {rx_start_o, rx_bit_valid_o, rx_bit_o, rx_bit_coll_o, rx_end_o} = 5'h00;
    forever
    begin
      @(posedge ref_clk_i);
      if (go_i)
      begin
        rx_start_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_start_o <= 1'b0;
        for (i = 0; i < nbits_i; i++)
        begin
          rx_bit_valid_o <= 1'b1;
          rx_bit_o <= data_i[i];
          rx_bit_coll_o <= coll_i[i];
          @(posedge ref_clk_i);
          rx_bit_valid_o <= 1'b0;
          rx_bit_o <= ~data_i[i];
          rx_bit_coll_o <= 1'b0;
          @(posedge ref_clk_i);
        end
        rx_end_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_end_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/rf_bit_framing_collision_ctrl_tb.sv ***
// Purpose: Self-checking bench for the bit framing block
// Assumes: Card model drives the bit stream
// Notes: Frame rows first, then interrupts, timers, transmit and reset
`timescale 1ns/1ps
`default_nettype none
module rf_bit_framing_collision_ctrl_tb;
  logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, act, tx_done, go, got;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, v;
  logic [31:0] c_data, c_coll;
  logic [5:0] c_bits;
  wire rs, rv, rb, rc, re, tx_start, bv, ts, tp, irq;
  wire [7:0] rdata, byte_o;
  wire [2:0] txl, ms;
  int fails, check_count;
  typedef struct {logic [2:0] al; logic k; logic [5:0] n; logic [31:0] d, c; logic [7:0] eb, el, ec;} row_t;
  row_t rows [6];
  rf_bit_framing_collision_ctrl rf_bit_framing_collision_ctrl_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .transceive_active_i(act), .tx_done_i(tx_done),
    .tx_start_o(tx_start), .transmit_last_bits_o(txl), .rx_start_i(rs), .rx_bit_valid_i(rv),
    .rx_bit_i(rb), .rx_bit_coll_i(rc), .rx_end_i(re), .rx_byte_valid_o(bv), .rx_byte_o(byte_o),
    .timer_start_strobe_o(ts), .timer_stop_strobe_o(tp), .modem_state_a_o(ms), .irq_o(irq));
  card_model card_model_inst (.ref_clk_i(ref_clk_i), .go_i(go), .data_i(c_data), .coll_i(c_coll),
    .nbits_i(c_bits), .rx_start_o(rs), .rx_bit_valid_o(rv), .rx_bit_o(rb), .rx_bit_coll_o(rc),
    .rx_end_o(re));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    {fails, check_count} = 0;
    {rst_n_i, reg_wr_i, reg_rd_i, act, tx_done, go, reg_addr_i, reg_wdata_i} = 0;
    {c_data, c_coll, c_bits} = 0;
    rows[0] = '{3'h0, 1'b1, 6'd8, 32'hA5, 32'h0, 8'hA5, 8'h10, 8'hA0};
    rows[1] = '{3'h3, 1'b1, 6'd5, 32'h16, 32'h0, 8'hB0, 8'h10, 8'hA0};
    rows[2] = '{3'h0, 1'b0, 6'd6, 32'h3F, 32'h4, 8'h07, 8'h16, 8'h03};
    rows[3] = '{3'h0, 1'b1, 6'd8, 32'hFF, 32'h80, 8'hFF, 8'h10, 8'h88};
    rows[4] = '{3'h0, 1'b1, 6'd32, 32'hC3, 32'h80000000, 8'hC3, 8'h10, 8'h80};
    rows[5] = '{3'h7, 1'b1, 6'd2, 32'h3, 32'h0, 8'h80, 8'h11, 8'hA0};
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      wr(6'h0D, {1'b0, rows[i].al, 4'h0});
      wr(6'h0E, {rows[i].k, 7'h00});
      c_data <= rows[i].d;
      c_coll <= rows[i].c;
      c_bits <= rows[i].n;
      go <= 1'b1;
      @(posedge ref_clk_i);
      go <= 1'b0;
      got = 1'b0;
      v = 8'hXX;
      repeat (120)
      begin
        @(posedge ref_clk_i);
        #1;
        if (bv === 1'b1 && !got)
        begin
          v = byte_o;
          got = 1'b1;
        end
      end
      chk("first byte", rows[i].eb, v);
      rdchk("last bits", 6'h0C, rows[i].el);
      rdchk("collision", 6'h0E, rows[i].ec);
    end
    chk("irq masked", 8'h00, {7'h00, irq});
    rdchk("irq status set", 6'h20, 8'h03);
    wr(6'h22, 8'h01);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("irq set", 8'h01, {7'h00, irq});
    wr(6'h21, 8'h07);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("irq clear", 8'h00, {7'h00, irq});
    rdchk("irq status", 6'h20, 8'h00);
    wr(6'h0C, 8'hC0);
    chk("timers", 8'h03, {6'h00, tp, ts});
    wr(6'h0D, 8'h07);
    @(posedge ref_clk_i);
    #1 chk("tx last", 8'h07, {5'h00, txl});
    rdchk("framing", 6'h0D, 8'h07);
    wr(6'h0D, 8'h80);
    act <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("wait state", 8'h01, {5'h00, ms});
    wr(6'h0D, 8'h80);
    got = 1'b0;
    for (int k = 0; k < 6 && !got; k++)
    begin
      @(posedge ref_clk_i);
      #1 got = (tx_start === 1'b1);
    end
    if (!got)
    begin
      fails++;
      report_and_stop;
    end
    chk("send state", 8'h03, {5'h00, ms});
    rdchk("irq tx start", 6'h20, 8'h04);
    tx_done <= 1'b1;
    @(posedge ref_clk_i);
    tx_done <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk("wait data", 8'h05, {5'h00, ms});
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk("receiving", 8'h06, {5'h00, ms});
    repeat (5) @(posedge ref_clk_i);
    #1 chk("rearmed", 8'h01, {5'h00, ms});
    act <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdchk("misc reset", 6'h0C, 8'h10);
    rdchk("framing reset", 6'h0D, 8'h00);
    rdchk("collision reset", 6'h0E, 8'hA0);
    wr(6'h0F, 8'hFF);
    rdchk("reserved 0f", 6'h0F, 8'h00);
    rdchk("reserved 10", 6'h10, 8'h00);
    rdchk("unmapped", 6'h3F, 8'h00);
    report_and_stop;
  end
endmodule
bind rf_bit_framing_collision_ctrl framing_checker framing_checker_inst (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .transceive_active_i(transceive_active_i),
  .tx_start_o(tx_start_o), .transmit_last_bits_o(transmit_last_bits_o),
  .rx_byte_valid_o(rx_byte_valid_o), .timer_start_strobe_o(timer_start_strobe_o),
  .timer_stop_strobe_o(timer_stop_strobe_o), .modem_state_a_o(modem_state_a_o));
`default_nettype wire
